// ---- core/cssr_pkg.sv ----
// Constants for the CPU system control and status register block
package cssr_pkg;
  localparam int unsigned DataWidth = 16;
  // Bit positions inside the control/status word
  localparam int unsigned BitFreeze = 15;
  localparam int unsigned BitCacheEn = 14;
  localparam int unsigned BitFlush = 13;
  localparam int unsigned BitHostIrq = 12;
  localparam int unsigned BitBusFault = 7;
  localparam int unsigned BitRomMap = 6;
  localparam int unsigned BitClkOff = 2;
  // Bits this block owns; other bits read as zero
  localparam logic [15:0] OwnedMask = 16'hf0c4;
  // Reset value except the strap-loaded ROM map bit
  localparam logic [15:0] ResetValue = 16'h1000;
  // Separation in instruction cycles after a ROM map change
  localparam logic [2:0] SepBitOpCat1 = 3'h4;
  localparam logic [2:0] SepBitOpCat2 = 3'h0;
  localparam logic [2:0] SepMmioCat1 = 3'h5;
  localparam logic [2:0] SepMmioCat2 = 3'h1;
  localparam logic [2:0] SepCat3 = 3'h0;
  // Default number of cache lines to invalidate
  localparam int unsigned CacheLines = 64;
  // Branch categories
  typedef enum logic [1:0] {
    CSSR_BR_CAT1 = 2'h0,
    CSSR_BR_CAT2 = 2'h1,
    CSSR_BR_CAT3 = 2'h2
  } cssr_br_cat_t;
endpackage

// ---- core/cssr_flush_seq.sv ----
// Cache flush sequencer: walks all lines, invalidating one per cycle
`timescale 1ns/1ps
`default_nettype none
module cssr_flush_seq #(
  parameter int unsigned LINES = cssr_pkg::CacheLines
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  output logic busy,
  output logic invValid,
  output logic [$clog2(LINES)-1:0] invIndex,
  output logic lastLine
);
  localparam logic [$clog2(LINES)-1:0] LastIdx = ($clog2(LINES))'(LINES - 1);
  logic [$clog2(LINES)-1:0] idx_r;
  logic busy_r;
  wire logic atLast = busy_r && (idx_r == LastIdx);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      idx_r <= '0;
    end else if (start && (!busy_r || atLast)) begin
      // Restart on the last line too, else the flush bit would stick high
      busy_r <= 1'b1;
      idx_r <= '0;
    end else if (busy_r) begin
      busy_r <= !atLast;
      idx_r <= atLast ? '0 : idx_r + 1'b1;
    end
  end

  assign busy = busy_r;
  assign invValid = busy_r;
  assign invIndex = idx_r;
  assign lastLine = atLast;
endmodule // cssr_flush_seq
`default_nettype wire

// ---- core/cssr_status_reg.sv ----
// CPU system control and status register with cache, clock-out and ROM-map control
// Overview of operation
// - Setting flush bit invalidates all cache lines
// - Flush bit reads one until flush done
// - Flush also discards the prefetch queue
// - Cache disabled: no requests reach cache
// - Cache enabled: fetch routed by address
// - Clearing cache enable empties prefetch queue
// - Freeze blocks miss fills, hits still served
// - Bus error sets fault and irq flags
// - Software writes of one to fault ignored
// - Fault cleared by zero write or reset
// - Clock-out disable bit gates clock pin
// - Host irq bit low gives host pulse
// - ROM map bit removes ROM when set
// - ROM map reset from strap; soft reset keeps
// - Bit-op change: category one needs four
// - Mapped write: five, one, zero cycles
// - Branch categories by kind of branch
// - Faulting instruction results not guaranteed
`timescale 1ns/1ps
`default_nettype none
module cssr_status_reg #(
  parameter int unsigned LINES = cssr_pkg::CacheLines
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Software reset instruction executing (one-cycle pulse)
  input wire logic softReset,
  // Strap level for the ROM map bit, held stable around reset release
  input wire logic romMapStrap,
  // Bit set/clear instruction port
  input wire logic bitOpValid,
  input wire logic bitOpSet,
  input wire logic [3:0] bitOpIndex,
  // Memory-mapped whole-word write and read
  input wire logic mmioWrite,
  input wire logic [15:0] mmioWdata,
  output logic [15:0] regRdata,
  // Internal bus error detected (one-cycle pulse)
  input wire logic busErrorDetect,
  output logic busFaultIrqSet,
  // CPU clock seen on the clock-out pin when enabled
  input wire logic clkSource,
  output logic clockOutPin,
  output logic hostIrqPin_n,
  // Program fetch routing
  input wire logic fetchReq,
  input wire logic fetchCacheable,
  output logic fetchToCache,
  output logic fetchToMemory,
  output logic cacheFillEnable,
  output logic prefetchFlush,
  output logic cacheInvValid,
  output logic [$clog2(LINES)-1:0] cacheInvIndex,
  output logic romMapped,
  // Branch hazard guard: stall while the ROM map change is settling
  input wire logic branchValid,
  input wire cssr_pkg::cssr_br_cat_t branchCat,
  output logic branchStall
);
  logic freeze_r, cacheEn_r, flush_r, hostIrq_r, fault_r, romMap_r, clock_out_disable_r;
  logic strapPending_r;
  logic [2:0] sepCat1_r, sepCat2_r;
  logic busFaultIrqSet_r, clockOutPin_r, hostIrqPin_r, fetchToCache_r, fetchToMemory_r;
  logic cacheFillEnable_r, prefetchFlush_r, romMapped_r, branchStall_r;
  logic [15:0] regRdata_r;
  logic seqBusy, seqLast;

  // Per-bit write decode shared by bit ops and mapped writes
  logic [15:0] bitWr, bitVal;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gDec
      assign bitWr[g] = mmioWrite || (bitOpValid && (bitOpIndex == 4'(g)));
      assign bitVal[g] = mmioWrite ? mmioWdata[g] : bitOpSet;
    end
  endgenerate

  wire logic flushStart = bitWr[cssr_pkg::BitFlush] && bitVal[cssr_pkg::BitFlush];
  wire logic cacheEnNxt = bitWr[cssr_pkg::BitCacheEn] ? bitVal[cssr_pkg::BitCacheEn]
                                                       : cacheEn_r;
  wire logic romMapNxt = bitWr[cssr_pkg::BitRomMap] ? bitVal[cssr_pkg::BitRomMap] : romMap_r;
  wire logic romChange = romMapNxt != romMap_r;
  // Set wins over a software clear in the same cycle
  wire logic faultNxt = busErrorDetect ? 1'b1
                      : (bitWr[cssr_pkg::BitBusFault] && !bitVal[cssr_pkg::BitBusFault])
                        ? 1'b0 : fault_r;
  wire logic flushNxt = flushStart ? 1'b1 : (seqLast ? 1'b0 : flush_r);
  wire logic [15:0] statusWord = {freeze_r, cacheEn_r, flush_r, hostIrq_r, 4'h0,
                                  fault_r, romMap_r, 3'h0, clock_out_disable_r, 2'h0}
                                 & cssr_pkg::OwnedMask;
  wire logic [2:0] cat1Load = mmioWrite ? cssr_pkg::SepMmioCat1 : cssr_pkg::SepBitOpCat1;
  wire logic [2:0] cat2Load = mmioWrite ? cssr_pkg::SepMmioCat2 : cssr_pkg::SepBitOpCat2;
  wire logic needStall = branchValid &&
                         ((branchCat == cssr_pkg::CSSR_BR_CAT1 && sepCat1_r != 3'h0) ||
                          (branchCat == cssr_pkg::CSSR_BR_CAT2 && sepCat2_r != 3'h0));

  cssr_flush_seq #(.LINES(LINES)) uFlush (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(flushStart),
    .busy(seqBusy),
    .invValid(cacheInvValid),
    .invIndex(cacheInvIndex),
    .lastLine(seqLast)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_r <= cssr_pkg::ResetValue[cssr_pkg::BitFreeze];
      cacheEn_r <= cssr_pkg::ResetValue[cssr_pkg::BitCacheEn];
      flush_r <= cssr_pkg::ResetValue[cssr_pkg::BitFlush];
      hostIrq_r <= cssr_pkg::ResetValue[cssr_pkg::BitHostIrq];
      fault_r <= cssr_pkg::ResetValue[cssr_pkg::BitBusFault];
      clock_out_disable_r <= cssr_pkg::ResetValue[cssr_pkg::BitClkOff];
    end else if (softReset) begin
      // Soft reset restores defaults; flush bit, fault flag and ROM map keep state
      freeze_r <= cssr_pkg::ResetValue[cssr_pkg::BitFreeze];
      cacheEn_r <= cssr_pkg::ResetValue[cssr_pkg::BitCacheEn];
      flush_r <= flushNxt;
      hostIrq_r <= cssr_pkg::ResetValue[cssr_pkg::BitHostIrq];
      fault_r <= faultNxt;
      clock_out_disable_r <= cssr_pkg::ResetValue[cssr_pkg::BitClkOff];
    end else begin
      freeze_r <= bitWr[cssr_pkg::BitFreeze] ? bitVal[cssr_pkg::BitFreeze] : freeze_r;
      cacheEn_r <= cacheEnNxt;
      flush_r <= flushNxt;
      hostIrq_r <= bitWr[cssr_pkg::BitHostIrq] ? bitVal[cssr_pkg::BitHostIrq] : hostIrq_r;
      // Only a bus error sets it
      fault_r <= faultNxt;
      clock_out_disable_r <= bitWr[cssr_pkg::BitClkOff] ? bitVal[cssr_pkg::BitClkOff] : clock_out_disable_r;
    end
  end

  // Strap caught after release, soft reset ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapPending_r <= 1'b1;
      romMap_r <= 1'b0;
    end else if (strapPending_r) begin
      strapPending_r <= 1'b0;
      romMap_r <= romMapStrap;
    end else begin
      romMap_r <= romMapNxt;
    end
  end

  // Separation counters after a ROM map change
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sepCat1_r <= 3'h0;
      sepCat2_r <= 3'h0;
    end else if (romChange && !strapPending_r) begin
      sepCat1_r <= cat1Load;
      sepCat2_r <= cat2Load;
    end else begin
      sepCat1_r <= (sepCat1_r != 3'h0) ? sepCat1_r - 3'h1 : 3'h0;
      sepCat2_r <= (sepCat2_r != 3'h0) ? sepCat2_r - 3'h1 : 3'h0;
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busFaultIrqSet_r <= 1'b0;
      clockOutPin_r <= 1'b0;
      hostIrqPin_r <= 1'b1;
      fetchToCache_r <= 1'b0;
      fetchToMemory_r <= 1'b0;
      cacheFillEnable_r <= 1'b0;
      prefetchFlush_r <= 1'b0;
      romMapped_r <= 1'b0;
      branchStall_r <= 1'b0;
      regRdata_r <= 16'h0000;
    end else begin
      // Fault raises the irq flag set
      busFaultIrqSet_r <= busErrorDetect;
      clockOutPin_r <= clkSource && !clock_out_disable_r;
      // Pin follows bit: clear then set pulses low
      hostIrqPin_r <= hostIrq_r;
      fetchToCache_r <= fetchReq && cacheEn_r && fetchCacheable && !seqBusy;
      fetchToMemory_r <= fetchReq && !(cacheEn_r && fetchCacheable && !seqBusy);
      // Frozen cache gets no miss fills
      cacheFillEnable_r <= cacheEn_r && !freeze_r && !seqBusy;
      prefetchFlush_r <= flushStart || (cacheEn_r && !cacheEnNxt);
      // ROM present only when bit is zero
      romMapped_r <= !romMap_r;
      branchStall_r <= needStall;
      regRdata_r <= statusWord;
    end
  end

  // No recovery of the faulting instruction
  assign busFaultIrqSet = busFaultIrqSet_r;
  assign clockOutPin = clockOutPin_r;
  assign hostIrqPin_n = hostIrqPin_r;
  assign fetchToCache = fetchToCache_r;
  assign fetchToMemory = fetchToMemory_r;
  assign cacheFillEnable = cacheFillEnable_r;
  assign prefetchFlush = prefetchFlush_r;
  assign romMapped = romMapped_r;
  assign branchStall = branchStall_r;
  assign regRdata = regRdata_r;
endmodule // cssr_status_reg
`default_nettype wire

// ---- verif/cssr_status_reg_asserts.sv ----
// Port-level assertions for the status register block
`timescale 1ns/1ps
`default_nettype none
module cssr_status_reg_asserts #(
  parameter int unsigned LINES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mmioWrite,
  input wire logic [15:0] mmioWdata,
  input wire logic [15:0] regRdata,
  input wire logic busErrorDetect,
  input wire logic busFaultIrqSet,
  input wire logic clkSource,
  input wire logic clockOutPin,
  input wire logic hostIrqPin_n,
  input wire logic prefetchFlush,
  input wire logic cacheInvValid,
  input wire logic romMapped
);
  int invCnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Length of the running invalidate burst
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) invCnt <= 0;
    else invCnt <= cacheInvValid ? invCnt + 1 : 0;
  end
  AST_FAULT_IRQ: assert property (busErrorDetect |=> busFaultIrqSet ##1 regRdata[7])
    else $error("bus fault not flagged");
  AST_FAULT_SRC: assert property ($rose(regRdata[7]) |-> $past(busErrorDetect, 2))
    else $error("fault set without bus error");
  AST_FAULT_CLR: assert property (mmioWrite && !mmioWdata[7] && !busErrorDetect |=> ##1 !regRdata[7])
    else $error("fault not cleared");
  AST_CLK_GATE: assert property ($past(rst_n) |-> clockOutPin == ($past(clkSource) && !regRdata[2]))
    else $error("clock-out gate wrong");
  AST_HOST_PIN: assert property ($past(rst_n) |-> hostIrqPin_n == regRdata[12])
    else $error("host pin differs from bit");
  AST_ROM_MAP: assert property ($past(rst_n) && $past(rst_n, 2) |-> romMapped == !regRdata[6])
    else $error("rom map output wrong");
  AST_FLUSH_LEN: assert property ($fell(cacheInvValid) |-> invCnt == LINES)
    else $error("flush did not walk every line");
  AST_FLUSH_BUSY: assert property (cacheInvValid && $past(cacheInvValid) |-> regRdata[13])
    else $error("flush bit low during flush");
  AST_FLUSH_PREF: assert property ($rose(cacheInvValid) |-> prefetchFlush)
    else $error("prefetch not discarded");
  cover property (cacheInvValid ##1 !cacheInvValid);
  cover property (busFaultIrqSet);
  cover property ($fell(hostIrqPin_n));
endmodule // cssr_status_reg_asserts
bind cssr_status_reg cssr_status_reg_asserts #(.LINES(LINES)) uAsserts (.sys_clk, .rst_n,
  .mmioWrite, .mmioWdata, .regRdata, .busErrorDetect, .busFaultIrqSet, .clkSource,
  .clockOutPin, .hostIrqPin_n, .prefetchFlush, .cacheInvValid, .romMapped);
`default_nettype wire

// ---- verif/cssr_cache_model.sv ----
// Instruction cache valid-bit model behind the invalidate and fill ports
`timescale 1ns/1ps
`default_nettype none
module cssr_cache_model #(
  parameter int unsigned LINES = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic invValid,
  input wire logic [$clog2(LINES)-1:0] invIndex,
  input wire logic fillEn,
  input wire logic fetchToCache,
  output logic [LINES-1:0] validMask
);
  // Invalidate wins over a fill in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) validMask <= '0;
    else if (invValid) validMask[invIndex] <= 1'b0;
    else if (fetchToCache && fillEn) validMask <= {validMask[LINES-2:0], 1'b1};
  end
endmodule // cssr_cache_model
`default_nettype wire

// ---- verif/cpu_sys_control_status_tb_top.sv ----
// Self-checking bench for the system control and status register
`timescale 1ns/1ps
`default_nettype none
module cpu_sys_control_status_tb_top;
  localparam int unsigned LN = 4;
  logic sys_clk = 1'b0, rst_n = 1'b0, softReset = 1'b0, romMapStrap = 1'b1, clkSource = 1'b0;
  logic bitOpValid = 1'b0, bitOpSet = 1'b0, mmioWrite = 1'b0, busErrorDetect = 1'b0;
  logic fetchReq = 1'b0, fetchCacheable = 1'b0, branchValid = 1'b0;
  logic [3:0] bitOpIndex = 4'h0;
  logic [15:0] mmioWdata = 16'h0000;
  cssr_pkg::cssr_br_cat_t branchCat = cssr_pkg::CSSR_BR_CAT1;
  logic busFaultIrqSet, clockOutPin, hostIrqPin_n, fetchToCache, fetchToMemory, cacheFillEnable;
  logic prefetchFlush, cacheInvValid, romMapped, branchStall;
  logic [$clog2(LN)-1:0] cacheInvIndex;
  logic [LN-1:0] validMask;
  logic [15:0] regRdata, expReg;
  logic [3:0] idx [5] = '{4'hf, 4'he, 4'hc, 4'h6, 4'h2};
  int cats [5] = '{0, 1, 0, 1, 2};
  int seps [5] = '{4, 0, 5, 1, 0};
  int n_mismatch = 0, total_checks = 0, n;
  cssr_status_reg #(.LINES(LN)) DUT (.sys_clk, .rst_n, .softReset, .romMapStrap, .bitOpValid,
    .bitOpSet, .bitOpIndex, .mmioWrite, .mmioWdata, .regRdata, .busErrorDetect, .busFaultIrqSet,
    .clkSource, .clockOutPin, .hostIrqPin_n, .fetchReq, .fetchCacheable, .fetchToCache,
    .fetchToMemory, .cacheFillEnable, .prefetchFlush, .cacheInvValid, .cacheInvIndex,
    .romMapped, .branchValid, .branchCat, .branchStall);
  cssr_cache_model #(.LINES(LN)) uCache (.sys_clk, .rst_n, .invValid(cacheInvValid),
    .invIndex(cacheInvIndex), .fillEn(cacheFillEnable), .fetchToCache, .validMask);
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) clkSource <= 1'($urandom);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task bop(input logic s, input logic [3:0] i);
    @(posedge sys_clk);
    bitOpValid <= 1'b1;
    bitOpSet <= s;
    bitOpIndex <= i;
    @(posedge sys_clk);
    bitOpValid <= 1'b0;
    if (i == 4'h7) expReg[7] = expReg[7] & s;
    else if (i != 4'hd) expReg[i] = s;
  endtask
  task wr(input logic [15:0] w);
    @(posedge sys_clk);
    mmioWrite <= 1'b1;
    mmioWdata <= w;
    @(posedge sys_clk);
    mmioWrite <= 1'b0;
    expReg = (w & 16'hd044) | (expReg & w & 16'h0080);
  endtask
  task rdchk;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(regRdata, expReg);
  endtask
  // Counts cycles a pulse output stands high, starting just after the taking edge
  task count(input int cyc, input int sel);
    n = 0;
    repeat (cyc) begin
      #1;
      n += (sel == 0) ? cacheInvValid : (sel == 1) ? prefetchFlush : branchStall;
      @(posedge sys_clk);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(39711));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    expReg = cssr_pkg::ResetValue | 16'h0040;
    repeat (2) @(posedge sys_clk);
    rdchk;
    chk(16'(romMapped), 16'h0000);
    $display("test reset done");
    @(posedge sys_clk);
    fetchReq <= 1'b1;
    fetchCacheable <= 1'b1;
    bop(1'b1, 4'hf);
    #1;
    chk(16'({fetchToCache, fetchToMemory, validMask}), 16'h0010);
    bop(1'b1, 4'he);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(16'({fetchToCache, validMask}), 16'h0010);
    bop(1'b0, 4'hf);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(16'(validMask == '0), 16'h0000);
    @(posedge sys_clk);
    fetchReq <= 1'b0;
    bop(1'b1, 4'hd);
    count(2 * LN + 4, 0);
    chk(16'(n), 16'(LN));
    chk(16'(validMask), 16'h0000);
    rdchk;
    bop(1'b0, 4'he);
    count(3, 1);
    chk(16'(n), 16'h0001);
    $display("test cache done");
    @(posedge sys_clk);
    busErrorDetect <= 1'b1;
    @(posedge sys_clk);
    busErrorDetect <= 1'b0;
    #1;
    chk(16'(busFaultIrqSet), 16'h0001);
    expReg[7] = 1'b1;
    rdchk;
    bop(1'b0, 4'h7);
    rdchk;
    bop(1'b1, 4'h7);
    rdchk;
    for (int v = 0; v < 2; v++) begin
      bop(v[0], 4'hc);
      rdchk;
      chk(16'(hostIrqPin_n), 16'(v));
    end
    $display("test fault and host done");
    for (int k = 0; k < 5; k++) begin
      @(posedge sys_clk);
      branchValid <= 1'b1;
      branchCat <= cssr_pkg::cssr_br_cat_t'(cats[k][1:0]);
      if (k < 2) bop(!expReg[6], 4'h6);
      else wr(expReg ^ 16'h0040);
      count(10, 2);
      chk(16'(n), 16'(seps[k]));
      branchValid <= 1'b0;
    end
    $display("test branch done");
    bop(1'b1, 4'hf);
    bop(1'b1, 4'h2);
    @(posedge sys_clk);
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
    expReg = (expReg & 16'h20c0) | 16'h1000;
    rdchk;
    repeat (24) begin
      if ($urandom_range(3) == 0) wr(16'($urandom) & 16'hdfff);
      else bop(1'($urandom), idx[$urandom_range(4)]);
      rdchk;
    end
    $display("test random done");
    print_verdict;
  end
  // Several times the expected run length
  initial begin
    #10000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end
endmodule // cpu_sys_control_status_tb_top
`default_nettype wire
